/* rstc_reset_controller.v */
// reset source controller: request gathering, sequencing, cause flags, apb
// How it works
// (R1) record the causing source after each reset
// (R2) power-on leaves only the power-on flag
// (R3) flags kept until written one; zero ignored
// (R4) every reset reloads fuse-loaded registers
// (R5) power-on request always enabled, both directions
// (R6) writing one to enable bit starts reset
// (R7) soft reset immediate, held until sequence ends
// (R8) pin low requests reset when fuse enables
// (R9) watchdog request enters reset
// (R10) debug request comes only from external debugger
// (R11) power-on resets every domain, override unavailable
// (R12) brown-out and user resets touch fewer domains
// (R13) init runs after release, fuse-lengthened
// (R14) controller works in every active and sleep mode
// (R15) software writes key then guarded write soon
// (R16) unguarded trigger write leaves register unchanged
// (R17) flag bits five to two per source
// (R18) power-on clears all flags but power-on
// (R19) trigger register index one, enable bit zero
// (R20) bit one brown-out, bit zero power-on
// (R21) enable bit always reads zero
// (R22) no other flag after power-on until boot
// (R23) every source active in episode is flagged; not one seen only in the reload cycle, nor others in power-on episodes
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "rstc_defs.vh"

module rstc_reset_controller #(
    parameter [15:0] INIT_BASE  = `RSTC_INIT_BASE,
    parameter [15:0] SUT_STEP   = `RSTC_SUT_STEP,
    parameter [15:0] CRC_EXTRA  = `RSTC_CRC_EXTRA,
    parameter [7:0]  UNLOCK_KEY = `RSTC_UNLOCK_KEY,
    parameter [2:0]  UNLOCK_WIN = `RSTC_UNLOCK_WIN
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // reset requests
    input  wire        por_req,
    input  wire        bod_req,
    input  wire        rst_pin_n,
    input  wire        wdt_req,
    input  wire        dbg_req,
    // fuse values
    input  wire        fuse_rst_pin_en,
    input  wire [2:0]  fuse_startup_time,
    input  wire        fuse_crc_select,
    // domain resets and status
    output wire        fuse_reload,
    output wire        sys_rst_n,
    output wire        dbg_rst_n,
    output wire        ovr_rst_n,
    output wire        bodcfg_rst_n,
    output wire        ovr_avail,
    output wire        reset_active
);

    localparam [3:0] ST_HOLD   = 4'h1;
    localparam [3:0] ST_RELOAD = 4'h2;
    localparam [3:0] ST_INIT   = 4'h4;
    localparam [3:0] ST_RUN    = 4'h8;

    // synchronisers: por, bod, pin, wdt, dbg
    reg  [4:0]  meta_ff;
    reg  [4:0]  sync_ff;

    // sequencer state
    reg  [3:0]  state_ff;
    reg  [3:0]  nxt_state;
    reg  [5:0]  pend_ff;
    reg  [5:0]  nxt_pend;
    reg         por_ep_ff;
    reg         nxt_por_ep;
    reg         bod_ep_ff;
    reg         nxt_bod_ep;
    reg  [15:0] cnt_ff;
    reg  [15:0] nxt_cnt;
    reg  [5:0]  flags_ff;
    reg  [5:0]  nxt_flags;
    reg         done;

    // fuse-loaded registers
    reg         pin_en_ff;
    reg  [2:0]  sut_ff;
    reg         crc_ff;

    // apb response
    reg         pready_ff;
    reg         pslverr_ff;
    reg  [31:0] prdata_ff;
    reg  [31:0] rd_word;
    reg         rd_map;

    // domain reset outputs
    reg         fuse_reload_ff;
    reg         sys_rst_n_ff;
    reg         dbg_rst_n_ff;
    reg         ovr_rst_n_ff;
    reg         bodcfg_rst_n_ff;
    reg         ovr_avail_ff;
    reg         reset_active_ff;

    wire        in_run;
    wire [7:0]  reg_idx;
    wire        addr_ok;
    wire        xfer_done;
    wire        wr_done;
    wire        unlocked;
    wire        key_hit;
    wire        trig_hit;
    wire        swr_req;
    wire [5:0]  req_vec;
    wire        req_any;
    wire [5:0]  clr_vec;
    wire        nxt_notrun;

    // cycles of internal initialization after every request is gone
    function [15:0] init_len;
        input [2:0] startup_time_fuse;
        input       crc;
        begin
            init_len = INIT_BASE + (SUT_STEP * {13'h0000, startup_time_fuse});
            if (crc) begin
                init_len = init_len + CRC_EXTRA;
            end
        end
    endfunction

    // true for a mapped word-aligned register index
    function hit_idx;
        input [11:0] addr;
        input [7:0]  idx;
        begin
            hit_idx = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) &&
                      (addr[9:2] == idx);
        end
    endfunction

    // two flops on every asynchronous request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 5'h00;
            sync_ff <= 5'h00;
        end else begin
            meta_ff <= {dbg_req, wdt_req, ~rst_pin_n, bod_req, por_req};
            sync_ff <= meta_ff;
        end
    end

    // bus decode; writes take effect at the completing edge only
    assign reg_idx   = paddr[9:2];
    assign addr_ok   = hit_idx(paddr, `RSTC_IDX_CAUSE) ||
                       hit_idx(paddr, `RSTC_IDX_SOFT_TRIG) ||
                       hit_idx(paddr, `RSTC_IDX_PROTECT) ||
                       hit_idx(paddr, `RSTC_IDX_FUSE_VIEW);
    assign xfer_done = psel && penable && pready_ff;
    assign wr_done   = xfer_done && pwrite && addr_ok && pstrb[0];
    assign key_hit   = wr_done && (reg_idx == `RSTC_IDX_PROTECT) &&
                       (pwdata[7:0] == UNLOCK_KEY);
    assign trig_hit  = wr_done && (reg_idx == `RSTC_IDX_SOFT_TRIG);
    assign swr_req   = trig_hit && unlocked &&
                       pwdata[`RSTC_SOFT_ENABLE_BIT]; // (R6) (R16) (R19)
    assign clr_vec   = (wr_done && (reg_idx == `RSTC_IDX_CAUSE)) ?
                       pwdata[5:0] : 6'h00; // (R3)

    rstc_unlock #(
        .UNLOCK_WIN (UNLOCK_WIN)
    ) u_unlock (
        .pclk      (pclk),
        .presetn   (presetn),
        .key_hit   (key_hit),
        .prot_hit  (trig_hit),
        .xfer_done (xfer_done),
        .unlocked  (unlocked)
    ); // (R15)

    // request vector lines up with the cause flag positions
    assign req_vec[`RSTC_POWERUP_BIT]    = sync_ff[0]; // (R5)
    assign req_vec[`RSTC_BROWNOUT_BIT]   = sync_ff[1];
    assign req_vec[`RSTC_PIN_BIT]        = sync_ff[2] && pin_en_ff; // (R8)
    assign req_vec[`RSTC_WATCHDOG_BIT]   = sync_ff[3]; // (R9)
    assign req_vec[`RSTC_SOFT_BIT]       = swr_req; // (R7)
    assign req_vec[`RSTC_DEBUG_PORT_BIT] = sync_ff[4]; // (R10)
    assign req_any = |req_vec;
    assign in_run  = (state_ff == ST_RUN);

    // sequencer: hold while requested, reload fuses, initialize, run
    always @* begin
        nxt_state  = state_ff;
        nxt_pend   = pend_ff;
        nxt_por_ep = por_ep_ff;
        nxt_bod_ep = bod_ep_ff;
        nxt_cnt    = cnt_ff;
        done       = 1'b0;
        case (state_ff)
            ST_RUN: begin
                if (req_any) begin
                    nxt_state  = ST_HOLD;
                    nxt_pend   = req_vec;
                    nxt_por_ep = req_vec[`RSTC_POWERUP_BIT];
                    nxt_bod_ep = req_vec[`RSTC_BROWNOUT_BIT];
                end
            end
            ST_HOLD: begin
                nxt_pend   = pend_ff | req_vec; // (R23)
                nxt_por_ep = por_ep_ff | req_vec[`RSTC_POWERUP_BIT];
                nxt_bod_ep = bod_ep_ff | req_vec[`RSTC_BROWNOUT_BIT];
                if (!req_any) begin
                    nxt_state = ST_RELOAD; // (R13)
                end
            end
            ST_RELOAD: begin
                nxt_cnt = init_len(fuse_startup_time,
                                   fuse_crc_select); // (R13)
                nxt_state = ST_INIT;
                if (req_any) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_INIT: begin
                if (req_any) begin
                    nxt_state  = ST_HOLD;
                    nxt_pend   = pend_ff | req_vec; // (R23)
                    nxt_por_ep = por_ep_ff | req_vec[`RSTC_POWERUP_BIT];
                    nxt_bod_ep = bod_ep_ff | req_vec[`RSTC_BROWNOUT_BIT];
                end else if (cnt_ff <= 16'h0001) begin
                    nxt_state = ST_RUN;
                    done      = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 16'h0001;
                end
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
    end

    // cause flags: a set at episode end wins over a same-cycle clear
    always @* begin
        nxt_flags = flags_ff & ~clr_vec; // (R3)
        if (done) begin
            if (por_ep_ff) begin
                nxt_flags = `RSTC_CAUSE_RST; // (R2) (R18) (R22)
            end else begin
                nxt_flags = nxt_flags | pend_ff; // (R1) (R17) (R20)
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= ST_HOLD;
            pend_ff    <= `RSTC_CAUSE_RST;
            por_ep_ff  <= 1'b1;
            bod_ep_ff  <= 1'b0;
            cnt_ff     <= 16'h0000;
            flags_ff   <= `RSTC_CAUSE_RST;
        end else begin
            state_ff   <= nxt_state; // (R14)
            pend_ff    <= nxt_pend;
            por_ep_ff  <= nxt_por_ep;
            bod_ep_ff  <= nxt_bod_ep;
            cnt_ff     <= nxt_cnt;
            flags_ff   <= nxt_flags;
        end
    end

    // fuse-loaded registers refresh in every episode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_en_ff <= 1'b0;
            sut_ff    <= `RSTC_SUT_RST;
            crc_ff    <= 1'b0;
        end else if (state_ff == ST_RELOAD) begin
            pin_en_ff <= fuse_rst_pin_en; // (R4)
            sut_ff    <= fuse_startup_time;
            crc_ff    <= fuse_crc_select;
        end
    end

    // domain resets follow the kind of episode
    assign nxt_notrun = (nxt_state != ST_RUN);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_reload_ff  <= 1'b0;
            sys_rst_n_ff    <= 1'b0;
            dbg_rst_n_ff    <= 1'b0;
            ovr_rst_n_ff    <= 1'b0;
            bodcfg_rst_n_ff <= 1'b0;
            ovr_avail_ff    <= 1'b0;
            reset_active_ff <= 1'b1;
        end else begin
            fuse_reload_ff  <= (nxt_state == ST_RELOAD); // (R4)
            sys_rst_n_ff    <= ~nxt_notrun; // (R7) (R12)
            dbg_rst_n_ff    <= ~(nxt_notrun &&
                                 (nxt_por_ep || nxt_bod_ep)); // (R12)
            ovr_rst_n_ff    <= ~(nxt_notrun && nxt_por_ep); // (R11)
            bodcfg_rst_n_ff <= ~(nxt_notrun && nxt_por_ep); // (R11)
            ovr_avail_ff    <= ~(nxt_notrun && nxt_por_ep); // (R11)
            reset_active_ff <= nxt_notrun;
        end
    end

    // read mux
    always @* begin
        rd_word = 32'h00000000;
        rd_map  = addr_ok;
        case (reg_idx)
            `RSTC_IDX_CAUSE: begin
                rd_word = {26'h0000000, flags_ff};
            end
            `RSTC_IDX_SOFT_TRIG: begin
                rd_word = 32'h00000000; // (R21)
            end
            `RSTC_IDX_PROTECT: begin
                rd_word = {31'h00000000, unlocked};
            end
            `RSTC_IDX_FUSE_VIEW: begin
                rd_word = {26'h0000000, ~in_run, crc_ff, sut_ff, pin_en_ff};
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
        if (!addr_ok) begin
            rd_word = 32'h00000000;
        end
    end

    // one wait state: pready rises in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else if (psel && penable && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= ~rd_map;
            prdata_ff  <= pwrite ? 32'h00000000 : rd_word;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end
    end

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign fuse_reload  = fuse_reload_ff;
    assign sys_rst_n    = sys_rst_n_ff;
    assign dbg_rst_n    = dbg_rst_n_ff;
    assign ovr_rst_n    = ovr_rst_n_ff;
    assign bodcfg_rst_n = bodcfg_rst_n_ff;
    assign ovr_avail    = ovr_avail_ff;
    assign reset_active = reset_active_ff;

endmodule

/* rstc_defs.vh */
// register map, field positions and counts for the reset source controller
`ifndef RSTC_DEFS_VH
`define RSTC_DEFS_VH

// register indexes; byte address is four times the index
`define RSTC_IDX_CAUSE       8'h00
`define RSTC_IDX_SOFT_TRIG   8'h01
`define RSTC_IDX_PROTECT     8'h02
`define RSTC_IDX_FUSE_VIEW   8'h03

// reset_cause_flags field positions
`define RSTC_POWERUP_BIT     0
`define RSTC_BROWNOUT_BIT    1
`define RSTC_PIN_BIT         2
`define RSTC_WATCHDOG_BIT    3
`define RSTC_SOFT_BIT        4
`define RSTC_DEBUG_PORT_BIT  5
`define RSTC_CAUSE_W         6

// software_reset_trigger field position
`define RSTC_SOFT_ENABLE_BIT 0

// reset values
`define RSTC_CAUSE_RST       6'h01
`define RSTC_SUT_RST         3'h0

// unlock key (arbitrary value) and window length in bus transfers
`define RSTC_UNLOCK_KEY      8'hA5
`define RSTC_UNLOCK_WIN      3'h4

// internal initialization lengths in pclk cycles
`define RSTC_INIT_BASE       16'h0040
`define RSTC_SUT_STEP        16'h0100
`define RSTC_CRC_EXTRA       16'h0800

`endif

/* rstc_unlock.v */
// unlock window for the protected software reset trigger register
`timescale 1ns/1ps
`include "rstc_defs.vh"

module rstc_unlock #(
    parameter [2:0] UNLOCK_WIN = `RSTC_UNLOCK_WIN
) (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // bus events
    input  wire       key_hit,
    input  wire       prot_hit,
    input  wire       xfer_done,
    // window state
    output wire       unlocked
);

    reg  [2:0] win_ff;
    reg  [2:0] nxt_win;

    // opens on the key, counts bus transfers, closes on the guarded write
    always @* begin
        nxt_win = win_ff;
        if (key_hit) begin
            nxt_win = UNLOCK_WIN;
        end else if (prot_hit) begin
            nxt_win = 3'h0;
        end else if (xfer_done && (win_ff != 3'h0)) begin
            nxt_win = win_ff - 3'h1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_ff <= 3'h0;
        end else begin
            win_ff <= nxt_win;
        end
    end

    assign unlocked = (win_ff != 3'h0);

endmodule

/* rstc_reset_controller_props.sv */
// assertion checker for the reset source controller ports
`timescale 1ns/1ps
module rstc_reset_controller_props (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb answer
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    // requests
    input wire        por_req,
    input wire        bod_req,
    input wire        wdt_req,
    input wire        dbg_req,
    // domain outputs
    input wire        fuse_reload,
    input wire        sys_rst_n,
    input wire        dbg_rst_n,
    input wire        ovr_rst_n,
    input wire        bodcfg_rst_n,
    input wire        ovr_avail,
    input wire        reset_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reload_pulse_a: assert property (
        fuse_reload |=> !fuse_reload && reset_active)
        else $error("fuse reload not one cycle inside episode");
    hold_match_a: assert property (
        reset_active == !sys_rst_n)
        else $error("system reset and active flag disagree");
    ovr_domain_a: assert property (
        ovr_avail == ovr_rst_n && bodcfg_rst_n == ovr_rst_n)
        else $error("override domains disagree");
    ovr_in_dbg_a: assert property (
        !ovr_rst_n |-> !dbg_rst_n)
        else $error("power-on episode left debug port running");
    dbg_in_sys_a: assert property (
        !dbg_rst_n |-> !sys_rst_n)
        else $error("debug reset outside system reset");
    por_enter_a: assert property (
        $rose(por_req) |-> ##[1:4] !ovr_rst_n)
        else $error("power-on request not taken");
    bod_enter_a: assert property (
        $rose(bod_req) |-> ##[1:4] !dbg_rst_n)
        else $error("brown-out request not taken");
    user_enter_a: assert property (
        $rose(wdt_req || dbg_req) |-> ##[1:4] !sys_rst_n)
        else $error("user request not taken");
    late_release_a: assert property (
        $rose(sys_rst_n) |-> !$past(por_req, 3) && !$past(bod_req, 3)
            && !$past(wdt_req, 3) && !$past(dbg_req, 3))
        else $error("released while a request was active");
    trig_zero_a: assert property (
        pready && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
        else $error("trigger register read not zero");
    cause_top_a: assert property (
        pready && !pwrite && paddr == 12'h000 |-> prdata[31:6] == 26'h0)
        else $error("unused cause bits not zero");
endmodule

bind rstc_reset_controller rstc_reset_controller_props u_props (
    .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .por_req(por_req),
    .bod_req(bod_req), .wdt_req(wdt_req), .dbg_req(dbg_req),
    .fuse_reload(fuse_reload), .sys_rst_n(sys_rst_n),
    .dbg_rst_n(dbg_rst_n), .ovr_rst_n(ovr_rst_n),
    .bodcfg_rst_n(bodcfg_rst_n), .ovr_avail(ovr_avail),
    .reset_active(reset_active)
);

/* rstc_source_model.sv */
// request source model: supplies, reset pin, watchdog, debug port
`timescale 1ns/1ps
module rstc_source_model (
    // clock
    input  wire       pclk,
    // sources held: por, bod, pin, wdt, dbg
    input  wire [4:0] hold,
    // request lines
    output reg        por_req,
    output reg        bod_req,
    output reg        rst_pin_n,
    output reg        wdt_req,
    output reg        dbg_req
);
    initial begin
        por_req = 1'b0;
        bod_req = 1'b0;
        rst_pin_n = 1'b1;
        wdt_req = 1'b0;
        dbg_req = 1'b0;
    end
    always @(posedge pclk) begin
        por_req <= hold[0];
        bod_req <= hold[1];
        rst_pin_n <= ~hold[2];
        wdt_req <= hold[3];
        dbg_req <= hold[4];
    end
endmodule

/* rstc_reset_controller_test.sv */
// testbench for the reset source controller
`timescale 1ns/1ps
module rstc_reset_controller_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        pin_en = 1'b1;
    logic [2:0]  startup_time_fuse = 3'h0;
    logic        crc = 1'b0;
    logic [4:0]  hold = 5'h00;
    wire  [31:0] prdata;
    wire         pready, pslverr, por_req, bod_req, rst_pin_n;
    wire         wdt_req, dbg_req, fuse_reload, sys_rst_n, dbg_rst_n;
    wire         ovr_rst_n, bodcfg_rst_n, ovr_avail, reset_active;
    wire  [4:0]  domains = {sys_rst_n, dbg_rst_n, ovr_rst_n, bodcfg_rst_n,
                            ovr_avail};
    int          n_errors = 0;
    int          samples_checked = 0;
    logic [31:0] flag [5] = '{32'h01, 32'h02, 32'h04, 32'h08, 32'h20};

    rstc_source_model src (.pclk(pclk), .hold(hold), .por_req(por_req),
        .bod_req(bod_req), .rst_pin_n(rst_pin_n), .wdt_req(wdt_req),
        .dbg_req(dbg_req));
    rstc_reset_controller #(.INIT_BASE(16'h0002), .SUT_STEP(16'h0001),
        .CRC_EXTRA(16'h0004)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .por_req(por_req), .bod_req(bod_req),
        .rst_pin_n(rst_pin_n), .wdt_req(wdt_req), .dbg_req(dbg_req),
        .fuse_rst_pin_en(pin_en), .fuse_startup_time(startup_time_fuse),
        .fuse_crc_select(crc), .fuse_reload(fuse_reload),
        .sys_rst_n(sys_rst_n), .dbg_rst_n(dbg_rst_n),
        .ovr_rst_n(ovr_rst_n), .bodcfg_rst_n(bodcfg_rst_n),
        .ovr_avail(ovr_avail), .reset_active(reset_active));

    initial forever #10 pclk = ~pclk;

    task automatic final_report;
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input [31:0] seen, input [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic timeout;
        n_errors++;
        $display("Error at %0t: wait ran out", $time);
        final_report();
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input w, input [11:0] a, input [31:0] d,
                       output [31:0] r, output e);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timeout();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input [11:0] a, input [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask
    // counts cycles from the reload pulse until the episode ends
    task automatic wait_run(output int n);
        int i;
        bit s;
        n = 0;
        s = 0;
        for (i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if (fuse_reload === 1'b1) s = 1;
            if (s) n++;
            if (s && reset_active === 1'b0) break;
        end
        if (i == 3000) timeout();
    endtask
    task automatic pulse(input [4:0] m, output int n);
        logic [4:0] dom;
        // supply episodes widen the set of domains held in reset
        dom = {1'b0, ~(m[0] | m[1]), {3{~m[0]}}};
        hold <= m;
        repeat (12) @(posedge pclk);
        check(reset_active, 1);
        check(domains, dom);
        hold <= 5'h00;
        wait_run(n);
    endtask

    initial begin
        int n, n0, k;
        logic [31:0] r;
        logic e;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wait_run(n0);
        rd(12'h000, 32'h01);
        rd(12'h004, 32'h00);
        rd(12'h00C, 32'h01);
        apb(1'b0, 12'h010, 32'h0, r, e);
        check(e, 1);
        wr(12'h000, 32'h00);
        rd(12'h000, 32'h01);
        wr(12'h000, 32'h01);
        rd(12'h000, 32'h00);
        wr(12'h004, 32'h01);
        repeat (8) @(posedge pclk);
        check(reset_active, 0);
        wr(12'h008, 32'hA5);
        wr(12'h004, 32'h01);
        check(reset_active, 1);
        wait_run(n);
        rd(12'h000, 32'h10);
        for (k = 1; k < 5; k++) begin
            wr(12'h000, 32'h3F);
            pulse(5'h01 << k, n);
            rd(12'h000, flag[k]);
        end
        wr(12'h000, 32'h3F);
        pulse(5'h18, n);
        rd(12'h000, 32'h28);
        pulse(5'h03, n);
        rd(12'h000, 32'h01);
        startup_time_fuse <= 3'h3;
        crc <= 1'b1;
        pin_en <= 1'b0;
        pulse(5'h08, n);
        check(n - n0, 7);
        rd(12'h00C, 32'h16);
        // pin low with its fuse copy cleared must not reset
        hold <= 5'h04;
        repeat (8) @(posedge pclk);
        check(reset_active, 0);
        hold <= 5'h00;
        final_report();
    end
endmodule
